// [hw/nest_int_consts.vh]
// constants for the nested interrupt priority controller
`ifndef NEST_INT_CONSTS_VH
`define NEST_INT_CONSTS_VH
// register byte addresses (chosen map)
`define ADDR_FLAGS 8'h00
`define ADDR_VPRIO0 8'h04
`define ADDR_VPRIO1 8'h08
`define ADDR_VPRIO2 8'h0C
`define ADDR_VPRIO3 8'h10
`define ADDR_SENSE 8'h14
`define ADDR_PEND 8'h18
`define ADDR_VECT 8'h1C
// flag register layout
`define FLG_HIGH 5
`define FLG_LOW 3
`define FLG_RESET 8'hEA
`define FLG_FIXED 8'hC0
// priority levels as two-bit codes
`define LVL0 2'h2
`define LVL1 2'h1
`define LVL2 2'h0
`define LVL3 2'h3
`define VPRIO_RESET 8'hFF
`define VPRIO3_FIXED 8'hF0
`define SENSE_RESET 8'h00
`define SENSE_WMASK 8'hFC
// sense field positions
`define SNS_HI_MSB 7
`define SNS_HI_LSB 6
`define POL_B 5
`define SNS_LO_MSB 4
`define SNS_LO_LSB 3
`define POL_A 2
// sense modes
`define SNS_FALL_LOW 2'h0
`define SNS_RISE 2'h1
`define SNS_FALL 2'h2
`define SNS_BOTH 2'h3
// vector slots
`define NSLOT 14
`define SLOT_NONE 4'hF
`define SLOT_EXT0 2
`define VEC_BASE 16'hFFFA
`define VEC_RESET 16'hFFFE
`define VEC_TRAP 16'hFFFC
`define USED_MASK 14'h03BE
`define WAKE_MASK 14'h00BE
// cpu operation codes
`define OP_NONE 3'h0
`define OP_ENABLE 3'h1
`define OP_DISABLE 3'h2
`define OP_WAIT 3'h3
`define OP_HALT 3'h4
`define OP_POP 3'h5
`define OP_RETURN 3'h6
`define OP_TRAP 3'h7
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [hw/nested_interrupt_priority.v]
// nested interrupt priority controller with axi4-lite register access
`timescale 1ns/1ps
`include "nest_int_consts.vh"
module nested_interrupt_priority (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // cpu operation strobe, popped flag value, halt state and acknowledge
  input wire [2:0] cpu_op,
  input wire [7:0] cpu_pop_flags,
  input wire cpu_halted,
  input wire cpu_ack,
  // interrupt sources: peripheral requests and external lines
  input wire [13:0] periph_req,
  input wire [13:0] src_enable,
  input wire [3:0] ext_line,
  // outputs to the cpu
  output reg int_req,
  output reg [15:0] int_vector,
  output reg wake,
  output reg branch_if_masked,
  output reg branch_if_unmasked,
  output reg [7:0] condition_flags
);

  // register state
  reg [7:0] vprio_r [0:3];
  reg [7:0] sense_r;
  reg [3:0] ext_pend_r;
  reg [3:0] ext_prev_r;
  reg [3:0] run_slot_r;
  reg [1:0] level_nxt;
  reg aw_got_r, w_got_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg [3:0] best_slot;
  reg [1:0] best_rank;
  reg best_ok;
  // separate loop indices keep each process the only driver of its own index
  integer ie, ip, ia, il;

  // rank of a level code: level 0 lowest, level 3 highest
  function [1:0] rank;
    input [1:0] code;
    begin
      case (code)
        `LVL0: rank = 2'h0;
        `LVL1: rank = 2'h1;
        `LVL2: rank = 2'h2;
        default: rank = 2'h3;
      endcase
    end
  endfunction

  // software level of slot s from its pair
  function [1:0] slot_level;
    input [3:0] s;
    reg [7:0] rv;
    begin
      rv = vprio_r[s[3:2]];
      slot_level = {rv[{s[1:0], 1'b1}], rv[{s[1:0], 1'b0}]};
    end
  endfunction

  // merge a written byte, keeping any pair written as level 0
  function [7:0] merge_prio;
    input [7:0] old_v;
    input [7:0] new_v;
    integer k;
    begin
      merge_prio = new_v;
      for (k = 0; k < 4; k = k + 1) begin
        if ({new_v[2*k+1], new_v[2*k]} == `LVL0) begin
          merge_prio[2*k+1] = old_v[2*k+1];
          merge_prio[2*k] = old_v[2*k];
        end
      end
    end
  endfunction

  wire [1:0] cur_level = {condition_flags[`FLG_HIGH], condition_flags[`FLG_LOW]};

  // edge and level detection per external line, polarity folded
  reg [3:0] ext_hit;
  reg [3:0] ext_level;
  reg [1:0] mode;
  reg inv;
  reg cur, prv;
  always @* begin
    ext_hit = 4'h0;
    ext_level = 4'h0;
    mode = `SNS_FALL_LOW;
    inv = 1'b0;
    cur = 1'b0;
    prv = 1'b0;
    // both samples are inverted before the edge test, so polarity swaps rise and fall
    // and turns falling-with-low into rising-with-high without a second correction
    for (ie = 0; ie < 4; ie = ie + 1) begin
      mode = (ie < 2) ? sense_r[`SNS_LO_MSB:`SNS_LO_LSB] : sense_r[`SNS_HI_MSB:`SNS_HI_LSB];
      // inversion only on lines 0 and 2 (the first line of each sense group)
      inv = (ie == 0) ? sense_r[`POL_A] : ((ie == 2) ? sense_r[`POL_B] : 1'b0);
      cur = ext_line[ie] ^ inv;
      prv = ext_prev_r[ie] ^ inv;
      case (mode)
        `SNS_FALL_LOW: begin
          ext_hit[ie] = prv & ~cur;
          ext_level[ie] = ~cur;
        end
        `SNS_RISE: ext_hit[ie] = ~prv & cur;
        `SNS_FALL: ext_hit[ie] = prv & ~cur;
        default: ext_hit[ie] = prv ^ cur;
      endcase
    end
  end

  // pending vector: external slots from latch or level, others from peripherals
  reg [13:0] pend;
  always @* begin
    pend = periph_req & `USED_MASK;
    // peripheral requests on external slots are ignored: those slots belong to the lines
    // a level-sensed line stays pending for as long as it is held active
    for (ip = 0; ip < 4; ip = ip + 1) begin
      pend[`SLOT_EXT0 + ip] = ext_pend_r[ip] | ext_level[ip];
    end
    // while halted only wake-capable slots may compete, so a timer cannot win first
    pend = pend & src_enable & `USED_MASK;
    if (cpu_halted)
      pend = pend & `WAKE_MASK;
  end

  // arbitration: software rank first, lowest slot on ties
  always @* begin
    best_slot = `SLOT_NONE;
    best_rank = 2'h0;
    best_ok = 1'b0;
    // scan from the lowest hardware priority upward; an equal rank found later
    // replaces the earlier one, so ties go to the lower slot number
    // the strict test against the current level keeps level 3 closed to all slots
    for (ia = `NSLOT - 1; ia >= 0; ia = ia - 1) begin
      if (pend[ia] && rank(slot_level(ia[3:0])) > rank(cur_level)
          && (!best_ok || rank(slot_level(ia[3:0])) >= best_rank)) begin
        best_ok = 1'b1;
        best_slot = ia[3:0];
        best_rank = rank(slot_level(ia[3:0]));
      end
    end
  end

  // next current level from entry and cpu operations
  // entry and trap take precedence over an operation code in the same cycle;
  // a return restores the level from the popped flag byte
  always @* begin
    level_nxt = cur_level;
    if (cpu_ack && cpu_op == `OP_TRAP)
      level_nxt = `LVL3;
    else if (cpu_ack && int_req)
      level_nxt = slot_level(run_slot_r);
    else begin
      case (cpu_op)
        `OP_ENABLE: level_nxt = `LVL0;
        `OP_DISABLE: level_nxt = `LVL3;
        `OP_WAIT: level_nxt = `LVL0;
        `OP_HALT: level_nxt = `LVL0;
        `OP_POP: level_nxt = {cpu_pop_flags[`FLG_HIGH], cpu_pop_flags[`FLG_LOW]};
        `OP_RETURN: level_nxt = {cpu_pop_flags[`FLG_HIGH], cpu_pop_flags[`FLG_LOW]};
        default: level_nxt = cur_level;
      endcase
    end
  end

  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  wire wr_hit_sense = wr_go && awaddr_r == `ADDR_SENSE && wstrb_r[0];
  wire sense_ok = cur_level == `LVL3;
  wire [7:0] sense_new = wdata_r[7:0] & `SENSE_WMASK;
  wire sense_chg = wr_hit_sense && sense_ok && sense_new != sense_r;

  // flags, priority regs, sense and external latches
  always @(posedge aclk) begin
    if (!aresetn) begin
      condition_flags <= `FLG_RESET;
      vprio_r[0] <= `VPRIO_RESET;
      vprio_r[1] <= `VPRIO_RESET;
      vprio_r[2] <= `VPRIO_RESET;
      vprio_r[3] <= `VPRIO_RESET;
      sense_r <= `SENSE_RESET;
      ext_pend_r <= 4'h0;
      // start from the live line level so that no false edge follows reset
      ext_prev_r <= ext_line;
      run_slot_r <= `SLOT_NONE;
      int_req <= 1'b0;
      int_vector <= `VEC_RESET;
      wake <= 1'b0;
      branch_if_masked <= 1'b1;
      branch_if_unmasked <= 1'b0;
    end else begin
      condition_flags[`FLG_HIGH] <= level_nxt[1];
      condition_flags[`FLG_LOW] <= level_nxt[0];
      condition_flags[7:6] <= 2'h3;
      if (cpu_op == `OP_POP || cpu_op == `OP_RETURN) begin
        condition_flags[4] <= cpu_pop_flags[4];
        condition_flags[2:0] <= cpu_pop_flags[2:0];
      end
      branch_if_masked <= level_nxt == `LVL3;
      branch_if_unmasked <= level_nxt != `LVL3;
      ext_prev_r <= ext_line;
      // latch edges; entry clears the served line, change of sense clears all
      // a new edge in the same cycle as a clear wins, so no event is lost
      for (il = 0; il < 4; il = il + 1) begin
        if (ext_hit[il])
          ext_pend_r[il] <= 1'b1;
        else if (sense_chg)
          ext_pend_r[il] <= 1'b0;
        else if (cpu_ack && int_req && run_slot_r == `SLOT_EXT0 + il)
          ext_pend_r[il] <= 1'b0;
      end
      if (sense_chg)
        sense_r <= sense_new;
      // priority register writes
      if (wr_go && wstrb_r[0]) begin
        if (awaddr_r == `ADDR_VPRIO0)
          vprio_r[0] <= merge_prio(vprio_r[0], wdata_r[7:0]);
        else if (awaddr_r == `ADDR_VPRIO1)
          vprio_r[1] <= merge_prio(vprio_r[1], wdata_r[7:0]);
        else if (awaddr_r == `ADDR_VPRIO2)
          vprio_r[2] <= merge_prio(vprio_r[2], wdata_r[7:0]);
        else if (awaddr_r == `ADDR_VPRIO3)
          vprio_r[3] <= merge_prio(vprio_r[3], wdata_r[7:0]) | `VPRIO3_FIXED;
      end
      // request toward the cpu; re-entry follows naturally from rank
      int_req <= best_ok && !(cpu_ack && int_req);
      wake <= |(pend & `WAKE_MASK);
      if (cpu_ack && cpu_op == `OP_TRAP)
        int_vector <= `VEC_TRAP;
      else if (best_ok) begin
        run_slot_r <= best_slot;
        int_vector <= `VEC_BASE - {11'h000, best_slot, 1'b0};
      end
    end
  end

  // axi4-lite write channel: address and data in either order
  // each ready pulses once per offer; the write lands the cycle after both are held
  // and a new pair is not committed while the previous response still waits
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r == `ADDR_VPRIO0 || awaddr_r == `ADDR_VPRIO1 ||
            awaddr_r == `ADDR_VPRIO2 || awaddr_r == `ADDR_VPRIO3 ||
            awaddr_r == `ADDR_SENSE)
          s_axi_bresp <= `RESP_OKAY;
        else if (awaddr_r == `ADDR_FLAGS || awaddr_r == `ADDR_PEND ||
                 awaddr_r == `ADDR_VECT)
          s_axi_bresp <= `RESP_OKAY; // read-only, write ignored
        else
          s_axi_bresp <= `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // word-aligned read address for decoding
  wire [7:0] ar_word = {s_axi_araddr[7:2], 2'h0};

  // axi4-lite read channel
  // data is taken at the address handshake and held with rvalid until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if (ar_word == `ADDR_FLAGS)
          s_axi_rdata <= {24'h000000, condition_flags};
        else if (ar_word == `ADDR_VPRIO0)
          s_axi_rdata <= {24'h000000, vprio_r[0]};
        else if (ar_word == `ADDR_VPRIO1)
          s_axi_rdata <= {24'h000000, vprio_r[1]};
        else if (ar_word == `ADDR_VPRIO2)
          s_axi_rdata <= {24'h000000, vprio_r[2]};
        else if (ar_word == `ADDR_VPRIO3)
          s_axi_rdata <= {24'h000000, vprio_r[3]};
        else if (ar_word == `ADDR_SENSE)
          s_axi_rdata <= {24'h000000, sense_r};
        else if (ar_word == `ADDR_PEND)
          s_axi_rdata <= {18'h00000, pend};
        else if (ar_word == `ADDR_VECT)
          s_axi_rdata <= {16'h0000, int_vector};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [testbench/nip_sva.sv]
// assertion checker for the nested interrupt priority controller
`timescale 1ns/1ps
`include "nest_int_consts.vh"
module nip_sva (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // cpu side
  input wire [2:0] cpu_op,
  input wire cpu_ack,
  input wire int_req,
  input wire [15:0] int_vector,
  input wire branch_if_masked,
  input wire branch_if_unmasked,
  input wire [7:0] condition_flags
);
  // current level pair and the operations that force it
  wire [1:0] lvl = {condition_flags[`FLG_HIGH], condition_flags[`FLG_LOW]};
  wire lvl3 = lvl == `LVL3;
  wire sleep_op = (cpu_op == `OP_WAIT || cpu_op == `OP_HALT) && !cpu_ack;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_masked_out: assert property (branch_if_masked == lvl3)
    else $error("masked branch wrong");
  a_unmasked_out: assert property (branch_if_unmasked == !lvl3)
    else $error("unmasked branch wrong");
  a_fixed_top: assert property (condition_flags[7:6] == 2'h3)
    else $error("flag top bits clear");
  a_enable_level: assert property (cpu_op == `OP_ENABLE && !cpu_ack |=> lvl == `LVL0)
    else $error("enable level wrong");
  a_disable_level: assert property (cpu_op == `OP_DISABLE |=> lvl3)
    else $error("disable level wrong");
  a_sleep_level: assert property (sleep_op |=> lvl == `LVL0)
    else $error("wait or halt level wrong");
  a_trap_level: assert property (cpu_op == `OP_TRAP && cpu_ack |=> lvl3)
    else $error("trap level wrong");
  a_blocked_top: assert property (lvl3 [*2] |-> !int_req)
    else $error("request at level 3");
  a_ack_drop: assert property (int_req && cpu_ack |=> !int_req)
    else $error("request kept after entry");
  a_vector_slot: assert property (int_req |-> int_vector[15:5] == 11'h7FF && !int_vector[0])
    else $error("vector outside slot table");
  // main scenarios reached
  c_entry: cover property (int_req && cpu_ack);
  c_trap: cover property (cpu_op == `OP_TRAP && cpu_ack);
  c_enable: cover property (cpu_op == `OP_ENABLE);
endmodule
bind nested_interrupt_priority nip_sva u_sva (.aclk, .aresetn, .cpu_op, .cpu_ack, .int_req,
  .int_vector, .branch_if_masked, .branch_if_unmasked, .condition_flags);

// [testbench/cpu_model.sv]
// cpu core model: enters requested routines after a set delay
`timescale 1ns/1ps
`include "nest_int_consts.vh"
module cpu_model (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // request side
  input wire int_req,
  input wire [2:0] cpu_op,
  input wire [3:0] dly,
  // acknowledge
  output wire cpu_ack
);
  logic ack_r;
  logic [3:0] cnt_r;
  // trap enters in its own cycle, so it is always taken
  assign cpu_ack = ack_r | (cpu_op == `OP_TRAP);
  // count request cycles, acknowledge once per request
  always @(posedge aclk) begin
    if (!aresetn || !int_req || ack_r) begin
      cnt_r <= 4'h0;
      ack_r <= 1'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      ack_r <= cnt_r == dly;
    end
  end
endmodule

// [testbench/testbench.sv]
// self-checking testbench for the nested interrupt priority controller
`timescale 1ns/1ps
`include "nest_int_consts.vh"
module testbench;
  // design inputs
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, cpu_halted = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, cpu_pop_flags = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF, ext_line = 4'hF, dly = 4'h2;
  logic [2:0] cpu_op = 0;
  logic [13:0] periph_req = 0, src_enable = 0;
  // design outputs
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_ack;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire int_req, wake, branch_if_masked, branch_if_unmasked;
  wire [15:0] int_vector;
  wire [7:0] condition_flags;
  integer bad_count = 0, checks_done = 0, i;
  // op code, popped flags, expected level
  logic [12:0] ops [0:6] = '{13'h0402, 13'h0803, 13'h0C02, 13'h1002, 13'h1700, 13'h1B21, 13'h1C03};

  nested_interrupt_priority DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_op, .cpu_pop_flags, .cpu_halted, .cpu_ack, .periph_req,
    .src_enable, .ext_line, .int_req, .int_vector, .wake, .branch_if_masked,
    .branch_if_unmasked, .condition_flags);
  cpu_model partner (.aclk, .aresetn, .int_req, .cpu_op, .dly, .cpu_ack);

  // clock
  always #2 aclk = ~aclk;

  task automatic chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // register write, address and data offered together
  task automatic wr(input [7:0] a, input [7:0] d, input [1:0] er);
    integer n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask

  // register read
  task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    integer n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask

  // one-cycle cpu operation, then the level it leaves
  task automatic op(input [2:0] o, input [7:0] p, input [1:0] el);
    @(posedge aclk);
    cpu_op <= o;
    cpu_pop_flags <= p;
    @(posedge aclk);
    cpu_op <= 3'h0;
    #1;
    chk({condition_flags[5], condition_flags[3]}, el);
  endtask

  // wait for a request, check its vector and the level loaded on entry
  task automatic svc(input [15:0] ev, input [1:0] el);
    integer n;
    n = 0;
    while (!int_req && n < 50) begin
      @(posedge aclk);
      n++;
    end
    #1;
    chk(int_vector, ev);
    do @(posedge aclk); while (!cpu_ack && n++ < 100);
    #1;
    chk({condition_flags[5], condition_flags[3]}, el);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`ADDR_FLAGS, `FLG_RESET, `RESP_OKAY);
    for (i = 1; i < 5; i++) rd(8'(4 * i), 32'hFF, `RESP_OKAY);
    rd(`ADDR_SENSE, 32'h0, `RESP_OKAY);
    rd(8'h20, 32'h0, `RESP_SLVERR);
    wr(8'h20, 8'h5A, `RESP_SLVERR);
    wr(`ADDR_VPRIO3, 8'h00, `RESP_OKAY);
    rd(`ADDR_VPRIO3, 32'hF0, `RESP_OKAY);
    wr(`ADDR_VPRIO0, 8'hCF, `RESP_OKAY);
    wr(`ADDR_VPRIO0, 8'h64, `RESP_OKAY);
    rd(`ADDR_VPRIO0, 32'h44, `RESP_OKAY);
    for (i = 0; i < 7; i++) op(ops[i][12:10], ops[i][9:2], ops[i][1:0]);
    // falling edge latched but held off at level 3, then cleared by a sense change
    wr(`ADDR_SENSE, 8'h10, `RESP_OKAY);
    rd(`ADDR_SENSE, 32'h10, `RESP_OKAY);
    src_enable <= 14'h0086;
    ext_line[0] <= 1'h0;
    repeat (3) @(posedge aclk);
    rd(`ADDR_PEND, 32'h4, `RESP_OKAY);
    wr(`ADDR_SENSE, 8'h08, `RESP_OKAY);
    rd(`ADDR_PEND, 32'h0, `RESP_OKAY);
    wr(`ADDR_SENSE, 8'h10, `RESP_OKAY);
    // software priority beats hardware order; sense locked below level 3
    wr(`ADDR_VPRIO0, 8'hD7, `RESP_OKAY);
    wr(`ADDR_VPRIO1, 8'h3F, `RESP_OKAY);
    op(`OP_ENABLE, 8'h00, `LVL0);
    wr(`ADDR_SENSE, 8'h00, `RESP_OKAY);
    rd(`ADDR_SENSE, 32'h10, `RESP_OKAY);
    dly <= 4'h6;
    periph_req <= 14'h0082;
    svc(16'hFFEC, `LVL2);
    @(posedge aclk) periph_req[7] <= 1'h0;
    repeat (5) @(posedge aclk);
    #1;
    chk(int_req, 1'h0);
    dly <= 4'h2;
    op(`OP_RETURN, 8'hE2, `LVL0);
    svc(16'hFFF8, `LVL1);
    @(posedge aclk) periph_req <= 14'h0;
    op(`OP_RETURN, 8'hE2, `LVL0);
    @(posedge aclk) ext_line[0] <= 1'h1;
    @(posedge aclk) ext_line[0] <= 1'h0;
    svc(16'hFFF6, `LVL1);
    rd(`ADDR_PEND, 32'h0, `RESP_OKAY);
    // halted: a timer request neither wakes nor pends, the time base wakes
    src_enable <= 14'h0186;
    cpu_halted <= 1'h1;
    periph_req <= 14'h0100;
    repeat (3) @(posedge aclk);
    #1;
    chk(wake, 1'h0);
    rd(`ADDR_PEND, 32'h0, `RESP_OKAY);
    @(posedge aclk) periph_req <= 14'h0002;
    repeat (3) @(posedge aclk);
    #1;
    chk(wake, 1'h1);
    @(posedge aclk) periph_req <= 14'h0;
    @(posedge aclk) cpu_halted <= 1'h0;
    end_sim;
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    bad_count++;
    end_sim;
  end
endmodule
